// ===== shared/dfps_regs.vh
// What this block does
// - page address comes from the high and low address byte registers
// - in data array mode, command 01H copies the addressed page into the four page data bytes
// - a byte takes programming only while it holds FFH
// - every erase clears at least the whole four-byte page
// - 05H erases and 02H programs the addressed page; 04H verifies it in data array mode only
// - after verify the command register reads zero on match, nonzero otherwise
// - 06H erases the whole 4 kB data array, taking about 2 ms
// - the data array starts with every byte at FFH
// - page read and verify take 5 machine cycles, byte read takes 3
// - data page program 380 us, byte program 200 us, page erase 2 ms
// - program memory: page write 15 ms, erases 2 ms, byte write 200 us
// - the operation starts on the command write itself
// - the core is held from the command write until the operation ends
// - interrupts are not taken while an operation runs
// - timers and counters keep running while the core is held
// - the data array is 1024 pages of four bytes
// - 82H programs one byte at the full byte address; 81H reads one there in data array mode only
// - F0H targets program memory, 0FH the data array; data array after reset
`ifndef DFPS_REGS_VH
`define DFPS_REGS_VH

// ---------------------------------------------
// register selects
// ---------------------------------------------
`define DFPS_SEL_ADDR_HIGH  3'h0
`define DFPS_SEL_ADDR_LOW   3'h1
`define DFPS_SEL_DATA_ONE   3'h2
`define DFPS_SEL_DATA_TWO   3'h3
`define DFPS_SEL_DATA_THREE 3'h4
`define DFPS_SEL_DATA_FOUR  3'h5
`define DFPS_SEL_COMMAND    3'h6

// ---------------------------------------------
// command codes and values
// ---------------------------------------------
`define DFPS_CMD_PAGE_READ    8'h01
`define DFPS_CMD_PAGE_PROGRAM 8'h02
`define DFPS_CMD_PAGE_VERIFY  8'h04
`define DFPS_CMD_PAGE_ERASE   8'h05
`define DFPS_CMD_FULL_ERASE   8'h06
`define DFPS_CMD_BYTE_READ    8'h81
`define DFPS_CMD_BYTE_PROGRAM 8'h82
`define DFPS_CMD_DATA_MODE    8'h0F
`define DFPS_CMD_PROG_MODE    8'hF0
`define DFPS_RST_BYTE         8'h00
`define DFPS_ERASED_BYTE      8'hFF
`define DFPS_VERIFY_OK        8'h00

// ---------------------------------------------
// timing
// ---------------------------------------------
`define DFPS_CLK_PERIOD_NS    10
`define DFPS_MC_CLKS          12
`define DFPS_T_PAGE_READ_MC   5
`define DFPS_T_BYTE_READ_MC   3
`define DFPS_T_DM_PAGE_PROG_US 380
`define DFPS_T_BYTE_PROG_US   200
`define DFPS_T_PAGE_ERASE_MS  2
`define DFPS_T_FULL_ERASE_MS  2
`define DFPS_T_PM_PAGE_PROG_MS 15
`define DFPS_US2CYC(t) (((t)*1000+`DFPS_CLK_PERIOD_NS-1)/`DFPS_CLK_PERIOD_NS)
`define DFPS_MS2CYC(t) (((t)*1000000+`DFPS_CLK_PERIOD_NS-1)/`DFPS_CLK_PERIOD_NS)
`define DFPS_MC2CYC(t) ((t)*`DFPS_MC_CLKS)

`endif

// ===== src/dfps_top.v
`timescale 1ns/10ps
`include "dfps_regs.vh"

module dfps_top #(
   parameter integer ADDR_W       = 12,
   parameter integer CNT_W        = 21,
   parameter integer DM_PAGE_PROG = `DFPS_US2CYC(`DFPS_T_DM_PAGE_PROG_US),
   parameter integer BYTE_PROG    = `DFPS_US2CYC(`DFPS_T_BYTE_PROG_US),
   parameter integer PAGE_ERASE   = `DFPS_MS2CYC(`DFPS_T_PAGE_ERASE_MS),
   parameter integer FULL_ERASE   = `DFPS_MS2CYC(`DFPS_T_FULL_ERASE_MS),
   parameter integer PM_PAGE_PROG = `DFPS_MS2CYC(`DFPS_T_PM_PAGE_PROG_MS)
) (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst_b,
   // special-function register port
   input  wire        sfr_wr_en,
   input  wire [2:0]  sfr_sel,
   input  wire [7:0]  sfr_wdata,
   output reg  [7:0]  sfr_rdata,
   // core control
   output wire        core_hold,
   output wire        int_hold,
   output wire        periph_run,
   output wire        op_busy,
   // program memory request port
   output reg         pm_req,
   output reg  [7:0]  pm_cmd,
   output reg  [15:0] pm_addr,
   output reg  [7:0]  pm_wdata
);

   // ---------------------------------------------
   // state codes and timing
   // ---------------------------------------------
   localparam S_IDLE = 1'b0;
   localparam S_RUN  = 1'b1;
   localparam integer DEPTH     = 1 << ADDR_W;
   localparam integer PAGE_READ = `DFPS_MC2CYC(`DFPS_T_PAGE_READ_MC);
   localparam integer BYTE_READ = `DFPS_MC2CYC(`DFPS_T_BYTE_READ_MC);

   // ---------------------------------------------
   // storage
   // ---------------------------------------------
   reg [7:0]        mem [0:DEPTH-1];
   reg [7:0]        addr_high_q;
   reg [7:0]        addr_low_q;
   reg [7:0]        data_one_q;
   reg [7:0]        data_two_q;
   reg [7:0]        data_three_q;
   reg [7:0]        data_four_q;
   reg [7:0]        cmd_q;
   reg              prog_mode_q;
   reg              state_q;
   reg [CNT_W-1:0]  cnt_q;
   reg              wipe_q;
   reg [ADDR_W-1:0] wipe_ptr_q;
   reg              op_pm_q;
   integer          i;

   // ---------------------------------------------
   // functions
   // ---------------------------------------------
   // true when the code starts a timed operation in the given target
   function is_op;
      input       pm;
      input [7:0] code;
      begin
         case (code)
            `DFPS_CMD_PAGE_PROGRAM,
            `DFPS_CMD_PAGE_ERASE,
            `DFPS_CMD_FULL_ERASE,
            `DFPS_CMD_BYTE_PROGRAM: is_op = 1'b1;
            `DFPS_CMD_PAGE_READ,
            `DFPS_CMD_PAGE_VERIFY,
            `DFPS_CMD_BYTE_READ: is_op = ~pm;
            default: is_op = 1'b0;
         endcase
      end
   endfunction

   // cycles an operation lasts, minus the final cycle
   function [CNT_W-1:0] duration;
      input       pm;
      input [7:0] code;
      reg [31:0]  t;
      begin
         t = 32'h0000_0001;
         case (code)
            `DFPS_CMD_PAGE_READ:    t = PAGE_READ;
            `DFPS_CMD_PAGE_VERIFY:  t = PAGE_READ;
            `DFPS_CMD_BYTE_READ:    t = BYTE_READ;
            `DFPS_CMD_PAGE_PROGRAM: t = pm ? PM_PAGE_PROG : DM_PAGE_PROG;
            `DFPS_CMD_PAGE_ERASE:   t = PAGE_ERASE;
            `DFPS_CMD_FULL_ERASE:   t = FULL_ERASE;
            `DFPS_CMD_BYTE_PROGRAM: t = BYTE_PROG;
            default:                t = 32'h0000_0001;
         endcase
         if (t == 32'h0000_0000) begin
            t = 32'h0000_0001;
         end
         t = t - 32'h0000_0001;
         duration = t[CNT_W-1:0];
      end
   endfunction

   // ---------------------------------------------
   // address forming and decode
   // ---------------------------------------------
   // page index in the low ten bits, byte index in the low twelve
   wire [15:0]       page_addr_full = {addr_high_q, addr_low_q};
   wire [9:0]        page_idx  = page_addr_full[9:0];
   wire [ADDR_W-1:0] byte_idx  = page_addr_full[ADDR_W-1:0];
   wire [ADDR_W-1:0] pg0 = {page_idx, 2'b00};
   wire [ADDR_W-1:0] pg1 = {page_idx, 2'b01};
   wire [ADDR_W-1:0] pg2 = {page_idx, 2'b10};
   wire [ADDR_W-1:0] pg3 = {page_idx, 2'b11};

   // a write to the command select is taken only while idle
   wire cmd_wr   = sfr_wr_en & (sfr_sel == `DFPS_SEL_COMMAND) & (state_q == S_IDLE);
   wire op_start = cmd_wr & is_op(prog_mode_q, sfr_wdata);
   wire op_done  = (state_q == S_RUN) & (cnt_q == {CNT_W{1'b0}}) & ~wipe_q;
   wire dm_done  = op_done & ~op_pm_q;

   // page compare for verify
   wire page_match = (mem[pg0] == data_one_q) & (mem[pg1] == data_two_q) &
                     (mem[pg2] == data_three_q) & (mem[pg3] == data_four_q);

   // ---------------------------------------------
   // core control
   // ---------------------------------------------
   // hold rises in the same cycle as the command write so the
   // next instruction can never slip in ahead of completion
   assign op_busy    = (state_q == S_RUN);
   assign core_hold  = op_busy | op_start;
   assign int_hold   = op_busy | op_start;
   // timers run off their own enable, never gated by the hold
   assign periph_run = 1'b1;

   // ---------------------------------------------
   // sequencer state and counter
   // ---------------------------------------------
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= S_IDLE;
         cnt_q      <= {CNT_W{1'b0}};
         wipe_q     <= 1'b0;
         wipe_ptr_q <= {ADDR_W{1'b0}};
         op_pm_q    <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (op_start) begin
                  state_q <= S_RUN;
                  cnt_q   <= duration(prog_mode_q, sfr_wdata);
                  op_pm_q <= prog_mode_q;
                  // data array wipe walks one byte per cycle inside the 2 ms
                  wipe_q  <= ~prog_mode_q & (sfr_wdata == `DFPS_CMD_FULL_ERASE);
                  wipe_ptr_q <= {ADDR_W{1'b0}};
               end
            end
            S_RUN: begin
               if (cnt_q != {CNT_W{1'b0}}) begin
                  cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
               end
               if (wipe_q) begin
                  wipe_ptr_q <= wipe_ptr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
                  if (wipe_ptr_q == {ADDR_W{1'b1}}) begin
                     wipe_q <= 1'b0;
                  end
               end
               if (op_done) begin
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // register file
   // ---------------------------------------------
   // software writes are dropped while busy; the core is held anyway
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_high_q  <= `DFPS_RST_BYTE;
         addr_low_q   <= `DFPS_RST_BYTE;
         data_one_q   <= `DFPS_RST_BYTE;
         data_two_q   <= `DFPS_RST_BYTE;
         data_three_q <= `DFPS_RST_BYTE;
         data_four_q  <= `DFPS_RST_BYTE;
         cmd_q        <= `DFPS_RST_BYTE;
         prog_mode_q  <= 1'b0;
      end else begin
         if (sfr_wr_en & (state_q == S_IDLE)) begin
            case (sfr_sel)
               `DFPS_SEL_ADDR_HIGH:  addr_high_q  <= sfr_wdata;
               `DFPS_SEL_ADDR_LOW:   addr_low_q   <= sfr_wdata;
               `DFPS_SEL_DATA_ONE:   data_one_q   <= sfr_wdata;
               `DFPS_SEL_DATA_TWO:   data_two_q   <= sfr_wdata;
               `DFPS_SEL_DATA_THREE: data_three_q <= sfr_wdata;
               `DFPS_SEL_DATA_FOUR:  data_four_q  <= sfr_wdata;
               `DFPS_SEL_COMMAND:    cmd_q        <= sfr_wdata;
               default: begin
               end
            endcase
         end
         // target switch takes effect for the next command
         if (cmd_wr & (sfr_wdata == `DFPS_CMD_PROG_MODE)) begin
            prog_mode_q <= 1'b1;
         end
         if (cmd_wr & (sfr_wdata == `DFPS_CMD_DATA_MODE)) begin
            prog_mode_q <= 1'b0;
         end
         if (dm_done & (cmd_q == `DFPS_CMD_PAGE_READ)) begin
            data_one_q   <= mem[pg0];
            data_two_q   <= mem[pg1];
            data_three_q <= mem[pg2];
            data_four_q  <= mem[pg3];
         end
         if (dm_done & (cmd_q == `DFPS_CMD_BYTE_READ)) begin
            data_one_q <= mem[byte_idx];
         end
         // a failed verify leaves the nonzero code in place
         if (dm_done & (cmd_q == `DFPS_CMD_PAGE_VERIFY) & page_match) begin
            cmd_q <= `DFPS_VERIFY_OK;
         end
      end
   end

   // ---------------------------------------------
   // data array
   // ---------------------------------------------
   // nonvolatile contents: no reset, shipped erased
   initial begin
      for (i = 0; i < DEPTH; i = i + 1) begin
         mem[i] = `DFPS_ERASED_BYTE;
      end
   end

   // array changes only at the end of an operation or during a wipe
   always @(posedge ref_clk) begin
      if (wipe_q) begin
         mem[wipe_ptr_q] <= `DFPS_ERASED_BYTE;
      end
      if (dm_done & (cmd_q == `DFPS_CMD_PAGE_ERASE)) begin
         mem[pg0] <= `DFPS_ERASED_BYTE;
         mem[pg1] <= `DFPS_ERASED_BYTE;
         mem[pg2] <= `DFPS_ERASED_BYTE;
         mem[pg3] <= `DFPS_ERASED_BYTE;
      end
      // a byte not at the erased value keeps its old contents
      if (dm_done & (cmd_q == `DFPS_CMD_PAGE_PROGRAM)) begin
         if (mem[pg0] == `DFPS_ERASED_BYTE) begin
            mem[pg0] <= data_one_q;
         end
         if (mem[pg1] == `DFPS_ERASED_BYTE) begin
            mem[pg1] <= data_two_q;
         end
         if (mem[pg2] == `DFPS_ERASED_BYTE) begin
            mem[pg2] <= data_three_q;
         end
         if (mem[pg3] == `DFPS_ERASED_BYTE) begin
            mem[pg3] <= data_four_q;
         end
      end
      if (dm_done & (cmd_q == `DFPS_CMD_BYTE_PROGRAM)) begin
         if (mem[byte_idx] == `DFPS_ERASED_BYTE) begin
            mem[byte_idx] <= data_one_q;
         end
      end
   end

   // ---------------------------------------------
   // program memory request and read-back
   // ---------------------------------------------
   // the program array is outside; it gets a one-cycle start pulse
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pm_req    <= 1'b0;
         pm_cmd    <= `DFPS_RST_BYTE;
         pm_addr   <= 16'h0000;
         pm_wdata  <= `DFPS_RST_BYTE;
         sfr_rdata <= `DFPS_RST_BYTE;
      end else begin
         pm_req <= op_start & prog_mode_q;
         if (op_start & prog_mode_q) begin
            pm_cmd   <= sfr_wdata;
            pm_addr  <= page_addr_full;
            pm_wdata <= data_one_q;
         end
         // read data follows the select one cycle later
         case (sfr_sel)
            `DFPS_SEL_ADDR_HIGH:  sfr_rdata <= addr_high_q;
            `DFPS_SEL_ADDR_LOW:   sfr_rdata <= addr_low_q;
            `DFPS_SEL_DATA_ONE:   sfr_rdata <= data_one_q;
            `DFPS_SEL_DATA_TWO:   sfr_rdata <= data_two_q;
            `DFPS_SEL_DATA_THREE: sfr_rdata <= data_three_q;
            `DFPS_SEL_DATA_FOUR:  sfr_rdata <= data_four_q;
            `DFPS_SEL_COMMAND:    sfr_rdata <= cmd_q;
            default:              sfr_rdata <= `DFPS_RST_BYTE;
         endcase
      end
   end

endmodule

// ===== tb/dfps_asserts.sv
`timescale 1ns/10ps
module dfps_asserts #(
   parameter integer DM_PAGE_PROG = 40,
   parameter integer BYTE_PROG    = 30,
   parameter integer PAGE_ERASE   = 50,
   parameter integer FULL_ERASE   = 50,
   parameter integer PM_PAGE_PROG = 45
) (
   // clock and reset
   input wire       ref_clk,
   input wire       rst_b,
   // register port
   input wire       sfr_wr_en,
   input wire [2:0] sfr_sel,
   input wire [7:0] sfr_wdata,
   // core control and program memory
   input wire       core_hold,
   input wire       int_hold,
   input wire       periph_run,
   input wire       op_busy,
   input wire       pm_req,
   input wire [7:0] pm_cmd
);
   // ----
   // helper state
   // ----
   reg     mode_q;
   integer run_q;
   integer exp_q;
   integer dur;
   wire    cmd_wr = sfr_wr_en && sfr_sel == 3'h6 && !op_busy;
   wire    start  = cmd_wr && dur != 0;
   // duration of the command on the bus, zero when nothing runs
   always @* begin
      case ({mode_q, sfr_wdata})
         9'h001, 9'h004: dur = 60;
         9'h081:         dur = 36;
         9'h002:         dur = DM_PAGE_PROG;
         9'h102:         dur = PM_PAGE_PROG;
         9'h082, 9'h182: dur = BYTE_PROG;
         9'h005, 9'h105: dur = PAGE_ERASE;
         9'h006:         dur = FULL_ERASE > 4097 ? FULL_ERASE : 4097; // wipe visits every byte
         9'h106:         dur = FULL_ERASE;
         default:        dur = 0;
      endcase
   end
   // target mode, busy run length and its due length
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= 1'b0;
         run_q  <= 0;
         exp_q  <= 0;
      end else begin
         if (cmd_wr && sfr_wdata == 8'hF0)
            mode_q <= 1'b1;
         if (cmd_wr && sfr_wdata == 8'h0F)
            mode_q <= 1'b0;
         if (start)
            exp_q <= dur;
         run_q <= op_busy ? run_q + 1 : 0;
      end
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   property p_run; periph_run; endproperty
   property p_int; int_hold == (op_busy || start); endproperty
   property p_busy; op_busy |-> core_hold; endproperty
   property p_start; start |-> core_hold ##1 op_busy; endproperty
   property p_free; !op_busy && !start |-> !core_hold; endproperty
   property p_noop; cmd_wr && dur == 0 |=> !op_busy; endproperty
   property p_len; $fell(op_busy) |-> run_q == exp_q; endproperty
   property p_pm; start && mode_q |=> pm_req && pm_cmd == $past(sfr_wdata) ##1 !pm_req; endproperty
   property p_pm_only; pm_req |-> $past(start && mode_q); endproperty
   a_run: assert property (p_run) else $error("timers gated");
   a_int: assert property (p_int) else $error("interrupt hold differs");
   a_busy: assert property (p_busy) else $error("core free while busy");
   a_start: assert property (p_start) else $error("command did not start");
   a_free: assert property (p_free) else $error("core held while idle");
   a_noop: assert property (p_noop) else $error("reserved code ran");
   a_len: assert property (p_len) else $error("busy length wrong");
   a_pm: assert property (p_pm) else $error("program memory request wrong");
   a_pm_only: assert property (p_pm_only) else $error("stray request");
   c_erase: cover property (start && sfr_wdata == 8'h06 && !mode_q);
   c_verify: cover property (start && sfr_wdata == 8'h04);
   c_pm: cover property (pm_req);
endmodule
bind dfps_top dfps_asserts #(
   .DM_PAGE_PROG(DM_PAGE_PROG), .BYTE_PROG(BYTE_PROG), .PAGE_ERASE(PAGE_ERASE),
   .FULL_ERASE(FULL_ERASE), .PM_PAGE_PROG(PM_PAGE_PROG)
) dfps_asserts_i (
   .ref_clk(ref_clk), .rst_b(rst_b), .sfr_wr_en(sfr_wr_en), .sfr_sel(sfr_sel),
   .sfr_wdata(sfr_wdata), .core_hold(core_hold), .int_hold(int_hold),
   .periph_run(periph_run), .op_busy(op_busy), .pm_req(pm_req), .pm_cmd(pm_cmd)
);

// ===== tb/dfps_core_model.sv
`timescale 1ns/10ps
module dfps_core_model (
   // clock
   input  wire       ref_clk,
   // register writes toward the sequencer
   output reg        sfr_wr_en,
   output reg  [2:0] sfr_sel,
   output reg  [7:0] sfr_wdata
);
   // idle bus at time zero
   initial begin
      sfr_wr_en = 1'b0;
      sfr_sel   = 3'h7;
      sfr_wdata = 8'h00;
   end
   // one-cycle strobe; address, data, then command is the caller's order
   task wr(input [2:0] s, input [7:0] d);
      begin
         @(posedge ref_clk) #1;
         sfr_wr_en = 1'b1;
         sfr_sel   = s;
         sfr_wdata = d;
         @(posedge ref_clk) #1;
         sfr_wr_en = 1'b0;
         sfr_wdata = ~d; // released data must not look valid
      end
   endtask
   // select only, for read-back
   task pick(input [2:0] s);
      begin
         @(posedge ref_clk) #1;
         sfr_sel = s;
      end
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
   localparam integer DMP = 40, BYP = 30, PER = 50, FER = 50, PMP = 45;
   reg         ref_clk;
   reg         rst_b;
   reg         rd_vld;
   wire        sfr_wr_en, core_hold, int_hold, periph_run, op_busy, pm_req;
   wire [2:0]  sfr_sel;
   wire [7:0]  sfr_wdata, sfr_rdata, pm_cmd, pm_wdata;
   wire [15:0] pm_addr;
   integer     fails, tests_run, n_busy, i, k;
   reg  [7:0]  d [0:3];
   reg  [7:0]  rq [$];
   reg  [31:0] pq [$];
   integer     dq [$];
   // ----
   // design and core model
   // ----
   dfps_top #(.DM_PAGE_PROG(DMP), .BYTE_PROG(BYP), .PAGE_ERASE(PER), .FULL_ERASE(FER),
      .PM_PAGE_PROG(PMP)) dfps_top_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .sfr_wr_en(sfr_wr_en), .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .core_hold(core_hold), .int_hold(int_hold), .periph_run(periph_run), .op_busy(op_busy),
      .pm_req(pm_req), .pm_cmd(pm_cmd), .pm_addr(pm_addr), .pm_wdata(pm_wdata));
   dfps_core_model dfps_core_model_i (.ref_clk(ref_clk), .sfr_wr_en(sfr_wr_en),
      .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata));
   // ----
   // checking and closing
   // ----
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks=%0d mismatches=%0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // read-back: the note is checked one edge after the data settles
   task rd(input [2:0] s, input [7:0] e);
      begin
         dfps_core_model_i.pick(s);
         @(posedge ref_clk) #1;
         rq.push_back(e);
         rd_vld = 1'b1;
         @(posedge ref_clk) #1;
         rd_vld = 1'b0;
      end
   endtask
   // command write, note its busy length, bounded wait for the end
   task cmd(input [7:0] c, input integer e);
      begin
         dfps_core_model_i.wr(3'h6, c);
         if (e > 0)
            dq.push_back(e);
         for (k = 0; k < 6000 && op_busy !== 1'b0; k = k + 1)
            @(posedge ref_clk) #1;
         if (k == 6000) begin
            fails = fails + 1;
            print_verdict;
         end
      end
   endtask
   // program memory command with the request it must raise
   task pmc(input [7:0] c, input integer e);
      begin
         pq.push_back({c, 16'h0A0D, 8'hFF});
         cmd(c, e);
      end
   endtask
   // observers take the oldest note when a result shows
   always @(posedge ref_clk) begin
      if (rd_vld)
         chk(sfr_rdata, rq.pop_front());
      if (pm_req === 1'b1)
         chk({pm_cmd, pm_addr, pm_wdata}, pq.pop_front());
      if (op_busy === 1'b1)
         n_busy = n_busy + 1;
      else if (n_busy > 0) begin
         chk(n_busy, dq.pop_front());
         n_busy = 0;
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ----
   // main sequence
   // ----
   initial begin
      fails = 0;
      tests_run = 0;
      n_busy = 0;
      rd_vld = 1'b0;
      rst_b = 1'b0;
      i = $urandom(86715);
      repeat (2) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      chk(periph_run, 1);
      for (i = 0; i < 8; i = i + 1)
         rd(3'(i), 8'h00);
      dfps_core_model_i.wr(3'h0, 8'h00);
      dfps_core_model_i.wr(3'h1, 8'h03);
      cmd(8'h01, 60);
      for (i = 0; i < 4; i = i + 1)
         rd(3'(i + 2), 8'hFF);
      for (i = 0; i < 4; i = i + 1) begin
         d[i] = 8'($urandom) & 8'hFE; // never erased value
         dfps_core_model_i.wr(3'(i + 2), d[i]);
      end
      cmd(8'h02, DMP);
      cmd(8'h04, 60);
      rd(3'h6, 8'h00);
      for (i = 0; i < 4; i = i + 1)
         dfps_core_model_i.wr(3'(i + 2), ~d[i]);
      cmd(8'h02, DMP);
      cmd(8'h01, 60);
      for (i = 0; i < 4; i = i + 1)
         rd(3'(i + 2), d[i]);
      dfps_core_model_i.wr(3'h2, ~d[0]);
      cmd(8'h04, 60);
      rd(3'h6, 8'h04);
      cmd(8'h05, PER);
      cmd(8'h01, 60);
      for (i = 0; i < 4; i = i + 1)
         rd(3'(i + 2), 8'hFF);
      dfps_core_model_i.wr(3'h0, 8'h0A);
      dfps_core_model_i.wr(3'h1, 8'h0D);
      dfps_core_model_i.wr(3'h2, 8'hF3);
      cmd(8'h82, BYP);
      dfps_core_model_i.wr(3'h2, 8'h00);
      cmd(8'h81, 36);
      rd(3'h2, 8'hF3);
      cmd(8'h06, 4097);
      cmd(8'h81, 36);
      rd(3'h2, 8'hFF);
      cmd(8'h03, 0);
      rd(3'h6, 8'h03);
      cmd(8'hF0, 0);
      cmd(8'h01, 0);
      cmd(8'h04, 0);
      cmd(8'h81, 0);
      pmc(8'h02, PMP);
      pmc(8'h05, PER);
      pmc(8'h06, FER);
      pmc(8'h82, BYP);
      cmd(8'h0F, 0);
      cmd(8'h81, 36);
      rd(3'h2, 8'hFF);
      repeat (3) @(posedge ref_clk);
      chk(pq.size(), 0);
      chk(dq.size(), 0);
      print_verdict;
   end
endmodule
